// ===== rtl/ivm_top.sv
// Interrupt vector map: picks a pending source and offers its vector word address.
`timescale 1ns/100ps
module ivm_top #(
	parameter int unsigned IRQ_N = ivm_pkg::IRQ_COUNT
) (
	input  wire logic                      core_clk,
	input  wire logic                      resetn,
	input  wire logic [IRQ_N-1:0]          irq_pending,
	input  wire logic [IRQ_N-1:0]          irq_enable,
	input  wire logic                      global_irq_enable,
	input  wire logic                      vector_ack,
	input  wire logic                      watchdog_reset_mode,
	output logic                           vector_valid,
	output logic [ivm_pkg::ADDR_W-1:0]     vector_addr,
	output logic                           vector_is_reset,
	output logic                           watchdog_irq_flag_clear,
	output logic                           watchdog_irq_enable_clear
);

	localparam int unsigned IW = $clog2(IRQ_N);

	ivm_pkg::ivm_state_t state;
	ivm_pkg::ivm_state_t next_state;

	logic [IRQ_N-1:0]           eligible;
	logic                       any_req;
	logic [IW-1:0]              win_idx;
	logic [IW-1:0]              held_idx;
	logic [ivm_pkg::ADDR_W-1:0] next_addr;
	logic                       take_wdog;

	// ------------------------------------------------------------
	// Eligibility and selection
	// ------------------------------------------------------------
	// Sources outside the global gate never reach the encoder.
	assign eligible = global_irq_enable ? (irq_pending & irq_enable) : '0; // RL16

	ivm_prio_enc #(
		.N  (IRQ_N),
		.IW (IW)
	) u_prio (
		.req (eligible),
		.any (any_req),
		.idx (win_idx)
	);

	// Vectors are packed one word apart, so the address is the index plus one.
	assign next_addr = ivm_pkg::ADDR_W'(win_idx) + ivm_pkg::ADDR_W'(1); // RL12 RL2 RL3 RL4 RL5 RL6 RL7 RL8 RL9 RL10 RL11

	// The offered vector only completes when the core acknowledges it.
	assign take_wdog = (state == ivm_pkg::IVM_OFFER) && vector_ack
		&& (held_idx == IW'(ivm_pkg::IRQ_WATCHDOG));

	always_comb begin
		next_state = state;
		case (state)
			ivm_pkg::IVM_BOOT: begin
				if (vector_ack) begin
					next_state = ivm_pkg::IVM_IDLE;
				end
			end
			ivm_pkg::IVM_IDLE: begin
				if (any_req) begin
					next_state = ivm_pkg::IVM_OFFER;
				end
			end
			ivm_pkg::IVM_OFFER: begin
				if (vector_ack) begin
					next_state = ivm_pkg::IVM_IDLE;
				end
			end
			default: begin
				next_state = ivm_pkg::IVM_IDLE;
			end
		endcase
	end

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	// Reset leaves the reset vector on offer until the core takes it.
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			state           <= ivm_pkg::IVM_BOOT;
			held_idx        <= '0;
			vector_valid    <= 1'b1;
			vector_addr     <= ivm_pkg::VEC_RESET; // RL1
			vector_is_reset <= 1'b1; // RL1
		end else begin
			state <= next_state;
			if (state == ivm_pkg::IVM_IDLE && any_req) begin
				held_idx        <= win_idx;
				vector_addr     <= next_addr;
				vector_valid    <= 1'b1;
				vector_is_reset <= 1'b0;
			end else if (vector_ack && state != ivm_pkg::IVM_IDLE) begin
				vector_valid    <= 1'b0;
				vector_is_reset <= 1'b0;
			end
		end
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			watchdog_irq_flag_clear   <= 1'b0;
			watchdog_irq_enable_clear <= 1'b0;
		end else begin
			watchdog_irq_flag_clear   <= take_wdog; // RL13
			watchdog_irq_enable_clear <= take_wdog && watchdog_reset_mode; // RL14
		end
	end

endmodule : ivm_top

// ===== rtl/ivm_pkg.sv
// Constants and types shared by the interrupt vector map.
// What this block does
// RL1: Any reset cause sends execution to word address 0x0000.
// RL2: External pin request A vectors to word address 0x0001.
// RL3: External pin request B vectors to word address 0x0002.
// RL4: Wide timer capture, match A, overflow vector to 0x0003, 0x0004, 0x0005.
// RL5: Wide timer match B vectors to word address 0x000C.
// RL6: Narrow timer overflow vectors to 0x0006, match A to 0x000D.
// RL7: Narrow timer match B vectors to word address 0x000E.
// RL8: Serial receive complete vectors to word address 0x0007.
// RL9: Serial transmit buffer empty vectors to word address 0x0008.
// RL10: Serial transmit complete vectors to word address 0x0009.
// RL11: Addresses 0x000A to 0x0012 hold comparator through watchdog vectors in order.
// RL12: Nineteen one-word vectors without gaps; vector N sits at address N-1.
// RL13: Taking the watchdog vector clears the watchdog interrupt flag in hardware.
// RL14: In interrupt-and-reset mode, taking it also clears the watchdog interrupt enable.
// RL15: Among pending enabled requests, the lowest vector address is served first.
// RL16: Vector only when global enable and the source enable are both set.
package ivm_pkg;

	// ------------------------------------------------------------
	// Vector table
	// ------------------------------------------------------------
	localparam int unsigned VEC_COUNT   = 19;
	localparam int unsigned IRQ_COUNT   = 18;
	localparam int unsigned ADDR_W      = 16;

	localparam logic [ADDR_W-1:0] VEC_RESET                      = 16'h0000;
	localparam logic [ADDR_W-1:0] VEC_EXT_PIN_IRQ_A              = 16'h0001;
	localparam logic [ADDR_W-1:0] VEC_EXT_PIN_IRQ_B              = 16'h0002;
	localparam logic [ADDR_W-1:0] VEC_WIDE_TIMER_CAPTURE         = 16'h0003;
	localparam logic [ADDR_W-1:0] VEC_WIDE_TIMER_MATCH_A         = 16'h0004;
	localparam logic [ADDR_W-1:0] VEC_WIDE_TIMER_OVERFLOW        = 16'h0005;
	localparam logic [ADDR_W-1:0] VEC_NARROW_TIMER_OVERFLOW      = 16'h0006;
	localparam logic [ADDR_W-1:0] VEC_SERIAL_RX_COMPLETE         = 16'h0007;
	localparam logic [ADDR_W-1:0] VEC_SERIAL_TX_BUFFER_EMPTY     = 16'h0008;
	localparam logic [ADDR_W-1:0] VEC_SERIAL_TX_COMPLETE         = 16'h0009;
	localparam logic [ADDR_W-1:0] VEC_ANALOG_COMPARATOR          = 16'h000A;
	localparam logic [ADDR_W-1:0] VEC_PIN_CHANGE_EVENT           = 16'h000B;
	localparam logic [ADDR_W-1:0] VEC_WIDE_TIMER_MATCH_B         = 16'h000C;
	localparam logic [ADDR_W-1:0] VEC_NARROW_TIMER_MATCH_A       = 16'h000D;
	localparam logic [ADDR_W-1:0] VEC_NARROW_TIMER_MATCH_B       = 16'h000E;
	localparam logic [ADDR_W-1:0] VEC_SERIAL_IF_START_CONDITION  = 16'h000F;
	localparam logic [ADDR_W-1:0] VEC_SERIAL_IF_COUNTER_OVERFLOW = 16'h0010;
	localparam logic [ADDR_W-1:0] VEC_NVM_READY                  = 16'h0011;
	localparam logic [ADDR_W-1:0] VEC_WATCHDOG_TIMEOUT           = 16'h0012;

	// Request bit i belongs to vector number i+2, at word address i+1.
	localparam int unsigned IRQ_WATCHDOG = 17;

	typedef enum logic [1:0] {
		IVM_IDLE,
		IVM_BOOT,
		IVM_OFFER
	} ivm_state_t;

endpackage : ivm_pkg

// ===== rtl/ivm_prio_enc.sv
// Fixed-priority encoder picking the lowest pending request.
`timescale 1ns/100ps
module ivm_prio_enc #(
	parameter int unsigned N  = 18,
	parameter int unsigned IW = 5
) (
	input  wire logic [N-1:0]  req,
	output logic               any,
	output logic [IW-1:0]      idx
);

	// ------------------------------------------------------------
	// Scan from the top so the lowest index is written last
	// ------------------------------------------------------------
	always_comb begin
		any = 1'b0;
		idx = '0;
		for (int i = N - 1; i >= 0; i--) begin
			if (req[i]) begin
				any = 1'b1;
				idx = IW'(i); // RL15
			end
		end
	end

endmodule : ivm_prio_enc

// ===== verif/ivm_core_model.sv
// Core model that takes each offered vector after a chosen wait.
`timescale 1ns/100ps
module ivm_core_model (
	input  wire logic core_clk,
	input  wire logic resetn,
	input  wire logic vector_valid,
	input  wire logic [3:0] ack_delay,
	output logic      vector_ack
);
	logic [3:0] cnt;
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			cnt <= 4'h0;
			vector_ack <= 1'b0;
		end else if (vector_ack) begin
			cnt <= 4'h0;
			vector_ack <= 1'b0;
		end else if (vector_valid) begin
			cnt <= cnt + 4'h1;
			vector_ack <= (cnt >= ack_delay);
		end
	end
endmodule : ivm_core_model

// ===== verif/ivm_top_asserts.sv
// Port checks for the interrupt vector map.
`timescale 1ns/100ps
module ivm_top_asserts (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic [17:0] irq_pending,
	input wire logic [17:0] irq_enable,
	input wire logic global_irq_enable,
	input wire logic vector_ack,
	input wire logic watchdog_reset_mode,
	input wire logic vector_valid,
	input wire logic [15:0] vector_addr,
	input wire logic vector_is_reset,
	input wire logic watchdog_irq_flag_clear,
	input wire logic watchdog_irq_enable_clear
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!resetn);
	wire take = !vector_valid && global_irq_enable && |(irq_pending & irq_enable);
	wire wd_ack = vector_valid && vector_ack && vector_addr == 16'h0012;
	sequence s_ack; vector_valid && vector_ack; endsequence
	boot_vec_a: assert property (vector_is_reset |-> vector_valid && vector_addr == 16'h0000)
		else $error("reset vector wrong");
	addr_range_a: assert property (vector_valid && !vector_is_reset |->
		vector_addr inside {[16'h0001:16'h0012]}) else $error("vector out of table");
	take_req_a: assert property (take |=> vector_valid) else $error("request not taken");
	mask_off_a: assert property (!vector_valid && !global_irq_enable |=> !vector_valid)
		else $error("offer while masked");
	offer_hold_a: assert property (vector_valid && !vector_ack |=>
		vector_valid && $stable(vector_addr)) else $error("offer changed");
	ack_gap_a: assert property (s_ack |=> !vector_valid) else $error("no gap after ack");
	wd_flag_a: assert property (wd_ack |=> watchdog_irq_flag_clear) else $error("flag kept");
	wd_en_a: assert property (wd_ack |=> watchdog_irq_enable_clear ==
		$past(watchdog_reset_mode)) else $error("enable clear wrong");
	flag_cause_a: assert property (watchdog_irq_flag_clear |-> $past(wd_ack))
		else $error("stray flag clear");
endmodule : ivm_top_asserts
bind ivm_top ivm_top_asserts u_chk (.*);

// ===== verif/testbench.sv
// Self-checking bench for the interrupt vector map.
`timescale 1ns/100ps
module testbench;
	logic core_clk = 0, resetn = 0, global_irq_enable = 1, watchdog_reset_mode = 0;
	logic [17:0] irq_pending = '0, irq_enable = '1;
	logic vector_ack, vector_valid, vector_is_reset, fc, ec;
	logic watchdog_irq_flag_clear, watchdog_irq_enable_clear;
	logic [15:0] vector_addr;
	logic [3:0] ack_delay = 4'h1;
	int error_cnt = 0, n_compared = 0;
	ivm_top u_ivm_top (.*);
	ivm_core_model u_ivm_core_model (.*);
	initial forever #2 core_clk = ~core_clk;
	task automatic chk(input string what, input logic [15:0] exp, got);
		n_compared++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD %s exp %h got %h", what, exp, got);
		end
	endtask : chk
	task automatic print_verdict;
		$display("compared %0d mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : print_verdict
	// Raise requests, check the offer, then catch the clear pulses as valid drops.
	task automatic offer(input logic [17:0] pend, input logic [15:0] exp);
		int n;
		@(negedge core_clk) irq_pending = pend;
		n = 0;
		while (vector_valid !== 1'b1 && n < 20) begin @(negedge core_clk); n++; end
		chk("offer valid", 16'h0001, {15'h0, vector_valid});
		chk("vector_addr", exp, vector_addr);
		chk("offer not reset", 16'h0000, {15'h0, vector_is_reset});
		irq_pending = '0;
		while (vector_valid !== 1'b0 && n < 40) begin @(negedge core_clk); n++; end
		chk("offer taken", 16'h0000, {15'h0, vector_valid});
		fc = watchdog_irq_flag_clear;
		ec = watchdog_irq_enable_clear;
	endtask : offer
	task automatic t_boot;
		@(negedge core_clk);
		chk("boot addr", 16'h0000, vector_addr);
		chk("boot flag", 16'h0001, {15'h0, vector_is_reset});
		repeat (1) @(negedge core_clk);
		resetn = 1;
		repeat (6) @(negedge core_clk);
		chk("boot done", 16'h0000, {15'h0, vector_valid});
	endtask : t_boot
	task automatic t_map;
		for (int i = 0; i < 18; i++) begin
			offer(18'h1 << i, 16'(i + 1));
			chk("flag clear", 16'(i == 17), {15'h0, fc});
			chk("enable clear", 16'h0000, {15'h0, ec});
		end
	endtask : t_map
	task automatic t_prio;
		offer(18'h2_0404, 16'h0003);
		offer(18'h3_1000, 16'h000D);
	endtask : t_prio
	task automatic t_mask;
		@(negedge core_clk) global_irq_enable = 0;
		irq_pending = 18'h0_0020;
		repeat (4) @(negedge core_clk);
		chk("global off", 16'h0000, {15'h0, vector_valid});
		global_irq_enable = 1;
		irq_enable = ~18'h0_0020;
		repeat (4) @(negedge core_clk);
		chk("source off", 16'h0000, {15'h0, vector_valid});
		irq_enable = '1;
		offer(18'h0_0020, 16'h0006);
	endtask : t_mask
	task automatic t_wdog;
		@(negedge core_clk) watchdog_reset_mode = 1;
		ack_delay = 4'h6;
		offer(18'h2_0000, 16'h0012);
		chk("wd flag clear", 16'h0001, {15'h0, fc});
		chk("wd enable clear", 16'h0001, {15'h0, ec});
	endtask : t_wdog
	initial begin
		#20000;
		error_cnt++;
		print_verdict();
	end
	initial begin
		t_boot();
		t_map();
		t_prio();
		t_mask();
		t_wdog();
		print_verdict();
	end
endmodule : testbench
